/* rtl/ivr_pkg.sv */
// shared constants and types for the interrupt vector and status readback block
// Notes on behaviour
// - thirty-two read-write handler words, reset zero
// - normal vector read returns current handler
// - current number indexes handler at read
// - no current interrupt returns spurious handler
// - fast vector read returns handler zero
// - no fast interrupt returns spurious handler
// - status reports current source number
// - pending bitmap shows pending sources
// - enabled bitmap shows enabled sources
// - core bit zero shows fast line active
// - core bit one shows normal line active
// - enabled bitmap resets to all zero
// - read with nothing enabled pending is spurious
// - general mask holds both lines inactive
// - non-fast sources carry priority zero to seven
package ivr_pkg;
    localparam int NUM_SRC = 32;
    localparam int PRIO_W = 3;
    localparam int ID_W = 5;
    localparam int FAST_SRC = 0;
    // register byte offsets inside the 4 KiB window
    localparam logic [11:0] OFF_PRIO_BASE = 12'h000;
    localparam logic [11:0] OFF_HANDLER_BASE = 12'h080;
    localparam logic [11:0] OFF_NORMAL_VEC = 12'h100;
    localparam logic [11:0] OFF_FAST_VEC = 12'h104;
    localparam logic [11:0] OFF_CUR_STATUS = 12'h108;
    localparam logic [11:0] OFF_PENDING = 12'h10c;
    localparam logic [11:0] OFF_ENABLED = 12'h110;
    localparam logic [11:0] OFF_CORE_LINE = 12'h114;
    localparam logic [11:0] OFF_ENABLE_CMD = 12'h120;
    localparam logic [11:0] OFF_DISABLE_CMD = 12'h124;
    localparam logic [11:0] OFF_SPURIOUS = 12'h134;
    localparam logic [11:0] OFF_LINE_CTRL = 12'h138;
    localparam logic [11:0] OFF_EV_STATUS = 12'h160;
    localparam logic [11:0] OFF_EV_CLEAR = 12'h164;
    localparam logic [11:0] OFF_EV_ENABLE = 12'h168;
    // field positions
    localparam int CTRL_PROT_BIT = 0;
    localparam int CTRL_GENERAL_LINE_MASK_BIT = 1;
    localparam int CORE_FAST_BIT = 0;
    localparam int CORE_NORMAL_BIT = 1;
    localparam int EV_SPURIOUS_BIT = 0;
    localparam int EV_VECTOR_BIT = 1;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef logic [NUM_SRC-1:0][PRIO_W-1:0] ivr_prio_t;
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACCESS = 2'b10} ivr_bus_e;

    typedef struct packed {
        logic hsel;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ivr_ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ivr_ahb_rsp_s;

    typedef struct packed {
        logic [NUM_SRC-1:0][31:0] handler;
        ivr_prio_t prio;
        logic [31:0] spurious;
        logic [NUM_SRC-1:0] enabled;
        logic [NUM_SRC-1:0] pending;
        logic prot;
        logic general_line_mask;
        logic cur_valid;
        logic [ID_W-1:0] cur_id;
        logic fast_n;
        logic normal_n;
        logic [1:0] ev_stat;
        logic [1:0] ev_en;
        logic ev_irq;
        logic [31:0] hrdata;
        logic hready;
        ivr_bus_e bus;
        logic ph_write;
        logic [11:0] ph_addr;
    } ivr_state_s;
endpackage

/* rtl/ivr_readback.sv */
// vector and status readback of a vectored interrupt controller, ahb-lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module ivr_readback
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire ivr_pkg::ivr_ahb_req_s ahb_i,
    input wire logic [ivr_pkg::NUM_SRC-1:0] src_i,
    output ivr_pkg::ivr_ahb_rsp_s ahb_o,
    output logic fast_request_line_n_o,
    output logic normal_request_line_n_o,
    output logic event_irq_o
);
    ivr_pkg::ivr_state_s state_ff;
    ivr_pkg::ivr_state_s nxt_state;
    logic [ivr_pkg::NUM_SRC-1:0] act;
    logic sel_valid;
    logic [ivr_pkg::ID_W-1:0] sel_id;
    logic fast_act;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic [4:0] widx;

    // handler and priority arrays occupy one word per source
    function automatic logic in_prio(input logic [11:0] a);
        return a[11:7] == ivr_pkg::OFF_PRIO_BASE[11:7];
    endfunction

    function automatic logic in_handler(input logic [11:0] a);
        return a[11:7] == ivr_pkg::OFF_HANDLER_BASE[11:7];
    endfunction

    // highest priority wins, ties go to the lower source number; fast source never takes part
    function automatic logic [ivr_pkg::ID_W:0] pick_normal(input logic [ivr_pkg::NUM_SRC-1:0] a,
                                                          input ivr_pkg::ivr_prio_t p);
        logic found;
        logic [ivr_pkg::ID_W-1:0] best;
        logic [ivr_pkg::PRIO_W-1:0] best_p;
        found = 1'b0;
        best = '0;
        best_p = '0;
        for (int i = 1; i < ivr_pkg::NUM_SRC; i++)
        begin
            if (a[i] && (!found || p[i] > best_p))
            begin
                found = 1'b1;
                best = i[ivr_pkg::ID_W-1:0];
                best_p = p[i];
            end
        end
        return {found, best};
    endfunction

    // arbitration on the registered pending and enabled maps
    assign act = state_ff.pending & state_ff.enabled;
    assign {sel_valid, sel_id} = pick_normal(act, state_ff.prio);
    assign fast_act = act[ivr_pkg::FAST_SRC];
    assign widx = state_ff.ph_addr[6:2];

    // every output but hresp is a field of the state register; hresp is tied low
    assign ahb_o.hrdata = state_ff.hrdata;
    assign ahb_o.hreadyout = state_ff.hready;
    assign ahb_o.hresp = 1'b0;
    assign fast_request_line_n_o = state_ff.fast_n;
    assign normal_request_line_n_o = state_ff.normal_n;
    assign event_irq_o = state_ff.ev_irq;

    // next state: lines, bus phases, register writes and read side effects
    always_comb
    begin
        nxt_state = state_ff;
        ev_set = 2'b00;
        ev_clr = 2'b00;
        nxt_state.pending = src_i;
        nxt_state.fast_n = !(fast_act && !state_ff.general_line_mask);
        nxt_state.normal_n = !(sel_valid && !state_ff.general_line_mask);
        nxt_state.ev_irq = |(state_ff.ev_stat & state_ff.ev_en);
        case (state_ff.bus)
            ivr_pkg::BUS_IDLE:
            begin
                // one wait state lets a read see a write that ended just before it
                if (ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready)
                begin
                    nxt_state.bus = ivr_pkg::BUS_ACCESS;
                    nxt_state.hready = 1'b0;
                    nxt_state.ph_write = ahb_i.hwrite;
                    nxt_state.ph_addr = ahb_i.haddr[11:0];
                end
            end
            ivr_pkg::BUS_ACCESS:
            begin
                nxt_state.bus = ivr_pkg::BUS_IDLE;
                nxt_state.hready = 1'b1;
                nxt_state.hrdata = ivr_pkg::RST_WORD;
                if (state_ff.ph_write)
                begin
                    if (in_prio(state_ff.ph_addr))
                    begin
                        nxt_state.prio[widx] = ahb_i.hwdata[ivr_pkg::PRIO_W-1:0];
                    end
                    else if (in_handler(state_ff.ph_addr))
                    begin
                        nxt_state.handler[widx] = ahb_i.hwdata;
                    end
                    else
                    begin
                        case (state_ff.ph_addr)
                            ivr_pkg::OFF_ENABLE_CMD: nxt_state.enabled = state_ff.enabled | ahb_i.hwdata;
                            ivr_pkg::OFF_DISABLE_CMD: nxt_state.enabled = state_ff.enabled & ~ahb_i.hwdata;
                            ivr_pkg::OFF_SPURIOUS: nxt_state.spurious = ahb_i.hwdata;
                            ivr_pkg::OFF_LINE_CTRL:
                            begin
                                nxt_state.prot = ahb_i.hwdata[ivr_pkg::CTRL_PROT_BIT];
                                nxt_state.general_line_mask = ahb_i.hwdata[ivr_pkg::CTRL_GENERAL_LINE_MASK_BIT];
                            end
                            ivr_pkg::OFF_EV_CLEAR: ev_clr = ahb_i.hwdata[1:0];
                            ivr_pkg::OFF_EV_ENABLE: nxt_state.ev_en = ahb_i.hwdata[1:0];
                            default: ;
                        endcase
                    end
                end
                else if (in_prio(state_ff.ph_addr))
                begin
                    nxt_state.hrdata = {29'h0000_0000, state_ff.prio[widx]};
                end
                else if (in_handler(state_ff.ph_addr))
                begin
                    nxt_state.hrdata = state_ff.handler[widx];
                end
                else
                begin
                    case (state_ff.ph_addr)
                        ivr_pkg::OFF_NORMAL_VEC:
                        begin
                            // the read itself latches the current source so id and vector agree
                            nxt_state.cur_valid = sel_valid;
                            nxt_state.cur_id = sel_valid ? sel_id : '0;
                            if (sel_valid)
                            begin
                                nxt_state.hrdata = state_ff.handler[sel_id];
                                ev_set[ivr_pkg::EV_VECTOR_BIT] = 1'b1;
                            end
                            else
                            begin
                                nxt_state.hrdata = state_ff.spurious;
                                ev_set[ivr_pkg::EV_SPURIOUS_BIT] = 1'b1;
                            end
                        end
                        ivr_pkg::OFF_FAST_VEC:
                        begin
                            nxt_state.hrdata = fast_act ? state_ff.handler[ivr_pkg::FAST_SRC] : state_ff.spurious;
                        end
                        ivr_pkg::OFF_CUR_STATUS: nxt_state.hrdata = {27'h000_0000, state_ff.cur_id};
                        ivr_pkg::OFF_PENDING: nxt_state.hrdata = state_ff.pending;
                        ivr_pkg::OFF_ENABLED: nxt_state.hrdata = state_ff.enabled;
                        ivr_pkg::OFF_CORE_LINE:
                        begin
                            nxt_state.hrdata[ivr_pkg::CORE_FAST_BIT] = !state_ff.fast_n;
                            nxt_state.hrdata[ivr_pkg::CORE_NORMAL_BIT] = !state_ff.normal_n;
                        end
                        ivr_pkg::OFF_SPURIOUS: nxt_state.hrdata = state_ff.spurious;
                        ivr_pkg::OFF_LINE_CTRL:
                        begin
                            nxt_state.hrdata[ivr_pkg::CTRL_PROT_BIT] = state_ff.prot;
                            nxt_state.hrdata[ivr_pkg::CTRL_GENERAL_LINE_MASK_BIT] = state_ff.general_line_mask;
                        end
                        ivr_pkg::OFF_EV_STATUS: nxt_state.hrdata = {30'h0000_0000, state_ff.ev_stat};
                        ivr_pkg::OFF_EV_ENABLE: nxt_state.hrdata = {30'h0000_0000, state_ff.ev_en};
                        default: nxt_state.hrdata = ivr_pkg::RST_WORD;
                    endcase
                end
            end
            default:
            begin
                nxt_state.bus = ivr_pkg::BUS_IDLE;
                nxt_state.hready = 1'b1;
            end
        endcase
        // a new event in the clearing cycle survives the clear
        nxt_state.ev_stat = (state_ff.ev_stat & ~ev_clr) | ev_set;
    end

    // single state register; lines idle high and the bus ready out of reset
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= '0;
            state_ff.bus <= ivr_pkg::BUS_IDLE;
            state_ff.hready <= 1'b1;
            state_ff.fast_n <= 1'b1;
            state_ff.normal_n <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // helper terms for the checks below
    logic rd_fire;
    logic wr_fire;
    logic [31:0] sel_vec;
    assign rd_fire = (state_ff.bus == ivr_pkg::BUS_ACCESS) && !state_ff.ph_write;
    assign wr_fire = (state_ff.bus == ivr_pkg::BUS_ACCESS) && state_ff.ph_write;
    assign sel_vec = state_ff.handler[sel_id];

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_addr_taken;
        (state_ff.bus == ivr_pkg::BUS_IDLE) && ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    endsequence

    sequence s_one_wait;
        !ahb_o.hreadyout ##1 ahb_o.hreadyout;
    endsequence

    a_bus_one_wait: assert property (s_addr_taken |=> s_one_wait)
        else $error("bus transfer did not take exactly one wait state");

    a_handler_store: assert property (wr_fire && in_handler(state_ff.ph_addr)
        |=> state_ff.handler[$past(widx)] == $past(ahb_i.hwdata))
        else $error("handler word not stored");

    a_normal_vector: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_NORMAL_VEC && sel_valid
        |=> ahb_o.hrdata == $past(sel_vec) && state_ff.cur_id == $past(sel_id) && state_ff.cur_valid)
        else $error("normal vector read returned wrong handler");

    a_normal_spurious: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_NORMAL_VEC && act == '0
        |=> ahb_o.hrdata == $past(state_ff.spurious) && !state_ff.cur_valid)
        else $error("spurious normal read returned wrong value");

    a_fast_vector: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_FAST_VEC
        |=> ahb_o.hrdata == ($past(fast_act) ? $past(state_ff.handler[0]) : $past(state_ff.spurious)))
        else $error("fast vector read returned wrong value");

    a_status_id: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_CUR_STATUS
        |=> ahb_o.hrdata == {27'h000_0000, $past(state_ff.cur_id)})
        else $error("status read returned wrong source number");

    a_pending_map: assert property (##1 state_ff.pending == $past(src_i))
        else $error("pending map does not follow sources");

    a_enable_cmd: assert property (wr_fire && state_ff.ph_addr == ivr_pkg::OFF_ENABLE_CMD
        |=> (state_ff.enabled & $past(ahb_i.hwdata)) == $past(ahb_i.hwdata))
        else $error("enable command did not set enabled bits");

    a_core_lines: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_CORE_LINE
        |=> ahb_o.hrdata[1:0] == {$past(!normal_request_line_n_o), $past(!fast_request_line_n_o)})
        else $error("core line status does not match lines");

    a_mask_reset: assert property (@(posedge clock_i) disable iff (1'b0)
        $rose(rstn_i) |-> state_ff.enabled == '0)
        else $error("enabled map not clear after reset");

    a_general_line_mask_lines: assert property (state_ff.general_line_mask |=> fast_request_line_n_o && normal_request_line_n_o)
        else $error("general mask did not hold lines inactive");

    a_normal_line: assert property (sel_valid && !state_ff.general_line_mask |=> !normal_request_line_n_o)
        else $error("normal line not active with enabled pending source");

    a_prio_pick: assert property (sel_valid |-> act[sel_id] && sel_id != 5'h00)
        else $error("arbiter picked an inactive or fast source");

    a_event_irq: assert property ((state_ff.ev_stat & state_ff.ev_en) != 2'b00 |=> event_irq_o)
        else $error("event interrupt output not raised");

    // data phases of the two vector reads, the steps that latch or return a handler
    sequence s_normal_read;
        rd_fire && (state_ff.ph_addr == ivr_pkg::OFF_NORMAL_VEC);
    endsequence

    sequence s_fast_read;
        rd_fire && (state_ff.ph_addr == ivr_pkg::OFF_FAST_VEC);
    endsequence

    // the identifier must come from the same arbitration as the returned vector
    a_cur_select: assert property ((s_normal_read ##0 sel_valid)
        |=> state_ff.cur_id == $past(sel_id))
        else $error("current number not latched from the arbiter");

    a_cur_none: assert property ((s_normal_read ##0 !sel_valid)
        |=> ahb_o.hrdata == $past(state_ff.spurious) && state_ff.cur_id == 5'h00)
        else $error("read with no current source not spurious");

    a_fast_spurious: assert property ((s_fast_read ##0 !fast_act)
        |=> ahb_o.hrdata == $past(state_ff.spurious))
        else $error("fast read without fast source not spurious");

    // an identifier that moved between reads would hand software the wrong source
    a_cur_hold: assert property (!rd_fire || state_ff.ph_addr != ivr_pkg::OFF_NORMAL_VEC
        |=> $stable(state_ff.cur_id))
        else $error("current number moved without a vector read");

    a_fast_line: assert property (fast_act && !state_ff.general_line_mask |=> !fast_request_line_n_o)
        else $error("fast line not active with fast source present");

    a_fast_idle: assert property (!fast_act |=> fast_request_line_n_o)
        else $error("fast line active without fast source");

    a_normal_idle: assert property (!sel_valid |=> normal_request_line_n_o)
        else $error("normal line active without a source");

    a_disable_cmd: assert property (wr_fire && state_ff.ph_addr == ivr_pkg::OFF_DISABLE_CMD
        |=> (state_ff.enabled & $past(ahb_i.hwdata)) == 32'h0000_0000)
        else $error("disable command left bits enabled");

    a_enabled_read: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_ENABLED
        |=> ahb_o.hrdata == $past(state_ff.enabled))
        else $error("enabled map read wrong");

    a_pending_read: assert property (rd_fire && state_ff.ph_addr == ivr_pkg::OFF_PENDING
        |=> ahb_o.hrdata == $past(state_ff.pending))
        else $error("pending map read wrong");

    a_handler_read: assert property (rd_fire && in_handler(state_ff.ph_addr)
        |=> ahb_o.hrdata == $past(state_ff.handler[widx]))
        else $error("handler word read wrong");

    // set wins over clear, so a spurious read is never lost
    a_event_spur: assert property ((s_normal_read ##0 !sel_valid) |=> state_ff.ev_stat[0])
        else $error("spurious event not recorded");

    a_event_clear: assert property (wr_fire && state_ff.ph_addr == ivr_pkg::OFF_EV_CLEAR
        |=> (state_ff.ev_stat & $past(ahb_i.hwdata[1:0])) == 2'b00)
        else $error("event clear did not clear status");
endmodule

/* bench/ivr_src_model.sv */
// behavioural model of the interrupt sources and the core's request inputs
`timescale 1ns/10ps
module ivr_src_model
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [31:0] want_i,
    input wire logic fast_request_line_n_i,
    input wire logic normal_request_line_n_i,
    output logic [31:0] src_o,
    output logic fast_seen_o,
    output logic normal_seen_o
);
    // sources move just after an edge, like peripherals on the same clock
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            src_o <= 32'h0;
        end
        else
        begin
            src_o <= want_i;
        end
    end
    // the core takes a request while its active-low line is low
    assign fast_seen_o = ~fast_request_line_n_i;
    assign normal_seen_o = ~normal_request_line_n_i;
endmodule

/* bench/tb.sv */
// self-checking testbench for the interrupt vector and status readback block
`timescale 1ns/10ps
module tb;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hsel = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] want = 32'h0;
    logic [31:0] src;
    logic fast_n;
    logic normal_n;
    logic fast_seen;
    logic normal_seen;
    logic ev_irq;
    ivr_pkg::ivr_ahb_req_s req;
    ivr_pkg::ivr_ahb_rsp_s rsp;
    int failures = 0;
    int num_checks = 0;

    // single slave, so its hreadyout is the bus hready
    assign req = {hsel, htrans, haddr, hwrite, hsize, hwdata, rsp.hreadyout};

    always #2 clock_i = ~clock_i;

    ivr_readback dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .ahb_i(req), .src_i(src), .ahb_o(rsp),
        .fast_request_line_n_o(fast_n), .normal_request_line_n_o(normal_n), .event_irq_o(ev_irq));
    ivr_src_model src_u (.clock_i(clock_i), .rstn_i(rstn_i), .want_i(want), .fast_request_line_n_i(fast_n),
        .normal_request_line_n_i(normal_n), .src_o(src), .fast_seen_o(fast_seen), .normal_seen_o(normal_seen));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one whole-word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        do begin @(posedge clock_i); n++; end while (rsp.hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge clock_i); n++; end while (rsp.hreadyout !== 1'b1 && n < 100);
        rd = rsp.hrdata;
        check("hresp", {31'h0, rsp.hresp}, 32'h0);
        if (n >= 100) check("bus_timeout", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(name, x, exp);
    endtask

    // model register stage plus the two edges from source to line
    task automatic settle();
        repeat (3) @(posedge clock_i);
        #1;
    endtask

    function automatic logic [31:0] hv(input int i);
        return 32'h8000_0000 ^ (i * 32'h0102_0408);
    endfunction

    task automatic t_reset();
        rdc("enabled", ivr_pkg::OFF_ENABLED, 32'h0);
        rdc("pending", ivr_pkg::OFF_PENDING, 32'h0);
        rdc("core", ivr_pkg::OFF_CORE_LINE, 32'h0);
        rdc("handler31", 12'h0fc, 32'h0);
        rdc("unmapped", 12'h118, 32'h0);
        check("fast_seen", {31'h0, fast_seen}, 32'h0);
        check("normal_seen", {31'h0, normal_seen}, 32'h0);
    endtask

    task automatic t_handlers();
        for (int i = 0; i < 32; i++) wr(ivr_pkg::OFF_HANDLER_BASE + 12'(4 * i), hv(i));
        for (int i = 0; i < 32; i++) rdc("handler", ivr_pkg::OFF_HANDLER_BASE + 12'(4 * i), hv(i));
        wr(ivr_pkg::OFF_SPURIOUS, 32'h5a5a_f00d);
        wr(ivr_pkg::OFF_NORMAL_VEC, 32'h1234_5678);
        rdc("spurious", ivr_pkg::OFF_SPURIOUS, 32'h5a5a_f00d);
    endtask

    task automatic t_bitmaps();
        want <= 32'hf0f0_0f0e;
        wr(ivr_pkg::OFF_ENABLE_CMD, 32'h8000_00a6);
        settle();
        rdc("pending", ivr_pkg::OFF_PENDING, 32'hf0f0_0f0e);
        rdc("enabled", ivr_pkg::OFF_ENABLED, 32'h8000_00a6);
        wr(ivr_pkg::OFF_DISABLE_CMD, 32'h8000_0002);
        rdc("enabled_after_off", ivr_pkg::OFF_ENABLED, 32'h0000_00a4);
        wr(ivr_pkg::OFF_DISABLE_CMD, 32'hffff_ffff);
        want <= 32'h0;
    endtask

    task automatic t_vectors();
        wr(ivr_pkg::OFF_PRIO_BASE + 12'h00c, 32'h2);
        wr(ivr_pkg::OFF_PRIO_BASE + 12'h01c, 32'h5);
        wr(ivr_pkg::OFF_PRIO_BASE + 12'h024, 32'h5);
        wr(ivr_pkg::OFF_ENABLE_CMD, 32'h0000_0288);
        want <= 32'h0000_0288;
        settle();
        rdc("normal_vec_tie", ivr_pkg::OFF_NORMAL_VEC, hv(7));
        rdc("cur_id", ivr_pkg::OFF_CUR_STATUS, 32'h7);
        rdc("prio7", ivr_pkg::OFF_PRIO_BASE + 12'h01c, 32'h5);
        rdc("core_normal", ivr_pkg::OFF_CORE_LINE, 32'h2);
        check("normal_seen", {31'h0, normal_seen}, 32'h1);
        wr(ivr_pkg::OFF_PRIO_BASE + 12'h00c, 32'h7);
        rdc("cur_id_held", ivr_pkg::OFF_CUR_STATUS, 32'h7);
        rdc("normal_vec_top", ivr_pkg::OFF_NORMAL_VEC, hv(3));
        rdc("cur_id_new", ivr_pkg::OFF_CUR_STATUS, 32'h3);
        wr(ivr_pkg::OFF_LINE_CTRL, 32'h3);
        settle();
        check("normal_masked", {31'h0, normal_seen}, 32'h0);
        rdc("core_masked", ivr_pkg::OFF_CORE_LINE, 32'h0);
        rdc("line_ctrl", ivr_pkg::OFF_LINE_CTRL, 32'h3);
        wr(ivr_pkg::OFF_LINE_CTRL, 32'h0);
        want <= 32'h0000_0001;
        settle();
        rdc("normal_spurious", ivr_pkg::OFF_NORMAL_VEC, 32'h5a5a_f00d);
        rdc("cur_id_none", ivr_pkg::OFF_CUR_STATUS, 32'h0);
        rdc("fast_spurious", ivr_pkg::OFF_FAST_VEC, 32'h5a5a_f00d);
        wr(ivr_pkg::OFF_ENABLE_CMD, 32'h0000_0001);
        settle();
        rdc("fast_vec", ivr_pkg::OFF_FAST_VEC, hv(0));
        rdc("core_fast", ivr_pkg::OFF_CORE_LINE, 32'h1);
        rdc("normal_fast_only", ivr_pkg::OFF_NORMAL_VEC, 32'h5a5a_f00d);
        wr(ivr_pkg::OFF_LINE_CTRL, 32'h2);
        settle();
        check("fast_masked", {31'h0, fast_seen}, 32'h0);
        wr(ivr_pkg::OFF_LINE_CTRL, 32'h0);
        want <= 32'h0;
    endtask

    // event interrupt: raise while masked, unmask, clear
    task automatic t_event();
        wr(ivr_pkg::OFF_EV_ENABLE, 32'h0);
        wr(ivr_pkg::OFF_EV_CLEAR, 32'h3);
        rdc("ev_clear", ivr_pkg::OFF_EV_STATUS, 32'h0);
        rdc("ev_spur_read", ivr_pkg::OFF_NORMAL_VEC, 32'h5a5a_f00d);
        rdc("ev_status", ivr_pkg::OFF_EV_STATUS, 32'h1);
        check("ev_irq_masked", {31'h0, ev_irq}, 32'h0);
        wr(ivr_pkg::OFF_EV_ENABLE, 32'h1);
        rdc("ev_enable", ivr_pkg::OFF_EV_ENABLE, 32'h1);
        settle();
        check("ev_irq_on", {31'h0, ev_irq}, 32'h1);
        wr(ivr_pkg::OFF_EV_CLEAR, 32'h1);
        settle();
        check("ev_irq_off", {31'h0, ev_irq}, 32'h0);
        rdc("ev_status_clr", ivr_pkg::OFF_EV_STATUS, 32'h0);
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // whole run is a few hundred cycles; this cuts a hang well past that
    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end

    initial
    begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_handlers();
        t_bitmaps();
        t_vectors();
        t_event();
        wrap_up();
    end
endmodule
